// File: hw/arx_baud_tick.sv
`timescale 1ns/1ps
// one-cycle sample strobe every baud_divisor_value+1 clocks
module arx_baud_tick
  import arx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [ARX_DIV_W-1:0] baud_divisor_value,
  // strobe
  output logic tick
);
  typedef struct packed {
    logic [ARX_DIV_W-1:0] cnt;
    logic tick;
  } arx_tick_s;
  arx_tick_s st_q, st_d;

  // down counter, reload on zero
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run) begin
      st_d.cnt = baud_divisor_value;
    end else if (st_q.cnt == '0) begin
      st_d.cnt = baud_divisor_value;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule : arx_baud_tick

// File: hw/arx_rx_recovery.sv
`timescale 1ns/1ps
// What this block does
// RL1: The line is sampled at 16 ticks per bit normally and 8 per bit in double speed.
// RL2: A high to low change starts start-bit detection with that first low sample as sample 1.
// RL3: The start bit is judged on samples 8,9,10 normally or 4,5,6 in double speed.
// RL4: Two or more high votes reject the start as noise and the receiver waits for a new edge.
// RL5: Bit timing restarts from each accepted start bit.
// RL6: Each start, data and parity bit is walked through 16 or 8 numbered sample states.
// RL7: Every bit takes the majority of its three center samples.
// RL8: Votes start at sample 8 (middle 9) normally and at 4 (middle 5) in double speed.
// RL9: Data, parity and only the first stop bit are recovered; later stop bits are ignored.
// RL10: A zero first stop bit raises the frame error flag for that frame.
// RL11: A new falling edge is accepted right after the last stop voting sample.
// RL12: Frames of five to ten data plus parity bits are handled.
// RL13: The remote sender keeps its rate inside the accepted slow and fast ratios.
// RL14: Receiver and sender each take about half of the rate error budget.
// RL15: Turning the receiver off stops reception at once and drops the frame.
// RL16: The line is synchronised by two flops and sampled on a baud tick.
module arx_rx_recovery
  import arx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic receiver_enable_bit,
  input wire logic double_speed_select,
  input wire logic [3:0] frame_bits,
  input wire logic [ARX_DIV_W-1:0] baud_divisor_value,
  // serial line
  input wire logic serial_receive_pin,
  // received frame
  output logic [9:0] rx_data,
  output logic frame_error_flag,
  output logic rx_valid,
  output logic busy
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    arx_state_e state;
    logic [4:0] sample;
    logic [3:0] bitn;
    logic [3:0] nbits;
    logic [2:0] votes;
    logic [9:0] shift;
    logic [9:0] data;
    logic ferr;
    logic valid;
    logic busy;
  } arx_rx_s;
  arx_rx_s st_q, st_d;
  logic tick;

  // majority of three samples
  function automatic logic vote3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : vote3

  // mode dependent first vote sample
  function automatic logic [4:0] first_vote(input logic dbl);
    return dbl ? ARX_VOTE_FIRST_DOUBLE : ARX_VOTE_FIRST_NORMAL;
  endfunction : first_vote

  // RL14 receiver rate from divisor
  // RL16 baud tick source
  arx_baud_tick u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(receiver_enable_bit),
    .baud_divisor_value(baud_divisor_value),
    .tick(tick)
  );

  logic [4:0] spb;
  logic [4:0] vfirst;
  logic line;
  logic [4:0] cur_sample;
  logic [2:0] vote_win;
  // RL1 samples per bit
  assign spb = double_speed_select ? ARX_SPB_DOUBLE : ARX_SPB_NORMAL;
  assign vfirst = first_vote(double_speed_select);
  assign line = st_q.sync2;
  // number of the sample taken at this tick while in bits
  assign cur_sample = (st_q.sample == spb) ? 5'h01 : st_q.sample + 5'h01;
  // two stored votes plus the sample taken now
  assign vote_win = {st_q.votes[1:0], line};

  // recovery state machine
  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    // RL16 two-flop synchroniser
    st_d.sync1 = serial_receive_pin;
    st_d.sync2 = st_q.sync1;
    if (!receiver_enable_bit) begin
      // RL15 immediate stop
      st_d.state = ARX_IDLE;
      st_d.prev = 1'b1;
      st_d.sample = '0;
    end else if (tick) begin
      st_d.prev = line;
      unique case (st_q.state)
        ARX_IDLE: begin
          // RL2 falling edge, sample one
          if (st_q.prev && !line) begin
            st_d.state = ARX_START;
            st_d.sample = 5'h01;
            st_d.votes = '0;
          end
        end
        ARX_START: begin
          st_d.sample = st_q.sample + 5'h01;
          // RL3 collect start votes
          if (st_q.sample + 5'h01 >= vfirst && st_q.sample + 5'h01 <= vfirst + 5'h02) begin
            st_d.votes = {st_q.votes[1:0], line};
          end
          if (st_q.sample == vfirst + 5'h02) begin
            if (vote3(st_q.votes)) begin
              // RL4 reject noise
              st_d.state = ARX_IDLE;
            end
          end
          if (st_q.sample == spb) begin
            // RL5 realign bit timing to this start
            st_d.state = ARX_BITS;
            st_d.sample = 5'h01;
            st_d.bitn = '0;
            st_d.votes = '0;
            // RL12 clamp frame length
            if (frame_bits < ARX_DBITS_MIN) begin
              st_d.nbits = ARX_DBITS_MIN;
            end else if (frame_bits > ARX_DBITS_MAX) begin
              st_d.nbits = ARX_DBITS_MAX;
            end else begin
              st_d.nbits = frame_bits;
            end
          end
        end
        ARX_BITS: begin
          // RL6 numbered sample states
          st_d.sample = cur_sample;
          // RL8 center samples
          if (cur_sample >= vfirst && cur_sample <= vfirst + 5'h02) begin
            st_d.votes = vote_win;
          end
          if (cur_sample == vfirst + 5'h02) begin
            if (st_q.bitn == st_q.nbits) begin
              // RL10 first stop bit decides frame error
              // RL9 later stop bits are not looked at
              // RL11 idle right after last vote
              st_d.ferr = ~vote3(vote_win);
              st_d.data = st_q.shift;
              st_d.valid = 1'b1;
              st_d.state = ARX_IDLE;
              st_d.prev = 1'b1;
            end else begin
              // RL7 majority vote, lsb first
              st_d.shift = '0;
              for (int i = 0; i < 10; i++) begin
                if (i[3:0] < st_q.bitn) begin
                  st_d.shift[i] = st_q.shift[i];
                end
              end
              st_d.shift[st_q.bitn] = vote3(vote_win);
            end
          end
          if (st_q.sample == spb) begin
            st_d.bitn = st_q.bitn + 4'h1;
          end
        end
        default: st_d.state = ARX_IDLE;
      endcase
    end
    st_d.busy = (st_d.state != ARX_IDLE); // registered busy
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, state: ARX_IDLE,
                sample: '0, bitn: '0, nbits: ARX_DBITS_MIN, votes: '0,
                shift: ARX_DATA_RESET, data: ARX_DATA_RESET, ferr: 1'b0, valid: 1'b0,
                busy: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign rx_data = st_q.data;
  assign frame_error_flag = st_q.ferr;
  assign rx_valid = st_q.valid;
  assign busy = st_q.busy;

  // tick at which the first stop bit is decided
  sequence s_stop_vote;
    receiver_enable_bit && tick && st_q.state == ARX_BITS
    && cur_sample == vfirst + 5'h02 && st_q.bitn == st_q.nbits;
  endsequence

  // RL15 disable drops the frame
  a_disable_stops: assert property (@(posedge clk_sys) disable iff (!resetn)
    !receiver_enable_bit |=> !busy && !rx_valid) else $error("busy after disable"); // RL15
  // RL4 noise goes back to idle
  a_start_noise_rej: assert property (@(posedge clk_sys) disable iff (!resetn)
    receiver_enable_bit && tick && st_q.state == ARX_START && st_q.sample == vfirst + 5'h02
    && vote3(st_q.votes) |=> st_q.state == ARX_IDLE) else $error("noise accepted"); // RL4
  // RL10 frame error from stop vote
  a_stop_ferr: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_stop_vote |=> rx_valid
    && (frame_error_flag == ($past(vote_win) inside {3'b000, 3'b001, 3'b010, 3'b100})))
    else $error("frame error mismatch"); // RL10
  // RL11 idle after valid
  a_idle_after: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_valid |-> st_q.state == ARX_IDLE) else $error("not idle after stop"); // RL11
  // RL6 sample range
  a_sample_range: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.state == ARX_BITS |-> st_q.sample >= 5'h01 && st_q.sample <= spb)
    else $error("sample out of range"); // RL6
  // RL2 edge starts detection at sample one
  a_edge_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    receiver_enable_bit && tick && st_q.state == ARX_IDLE && st_q.prev && !line
    |=> st_q.state == ARX_START && st_q.sample == 5'h01) else $error("edge missed"); // RL2
  // RL12 frame length clamp
  a_len_range: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.state == ARX_BITS |-> st_q.nbits >= ARX_DBITS_MIN && st_q.nbits <= ARX_DBITS_MAX)
    else $error("length out of range"); // RL12
  // RL5 bits begin at sample one
  a_resync_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(st_q.state == ARX_BITS) |-> st_q.sample == 5'h01 && st_q.bitn == 4'h0)
    else $error("no resync"); // RL5
endmodule : arx_rx_recovery

// File: pkg/arx_pkg.sv
package arx_pkg;
  // oversampling per bit and voting sample numbers
  localparam logic [4:0] ARX_SPB_NORMAL = 5'h10;
  localparam logic [4:0] ARX_SPB_DOUBLE = 5'h08;
  localparam logic [4:0] ARX_VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] ARX_VOTE_FIRST_DOUBLE = 5'h04;
  // frame length bounds (data plus parity)
  localparam logic [3:0] ARX_DBITS_MIN = 4'h5;
  localparam logic [3:0] ARX_DBITS_MAX = 4'ha;
  // baud divisor width and reset value
  localparam int ARX_DIV_W = 12;
  localparam logic [11:0] ARX_DIV_RESET = 12'h000;
  // reset values of outputs
  localparam logic [9:0] ARX_DATA_RESET = 10'h000;
  typedef enum logic [1:0] {ARX_IDLE, ARX_START, ARX_BITS} arx_state_e;
endpackage : arx_pkg

// File: tb/arx_rx_recovery_tb.sv
`timescale 1ns/1ps
module arx_rx_recovery_tb;
  import arx_pkg::*;
  logic clk_sys, resetn, en, ds, pin, fe, rx_valid, busy;
  logic [3:0] fb;
  logic [ARX_DIV_W-1:0] div;
  logic [9:0] rx_data, d, d2;
  logic [10:0] got_q[$];
  int n_fail, n_tests, seed, nb, bc;

  arx_rx_recovery dut (.clk_sys(clk_sys), .resetn(resetn), .receiver_enable_bit(en),
    .double_speed_select(ds), .frame_bits(fb), .baud_divisor_value(div),
    .serial_receive_pin(pin), .rx_data(rx_data), .frame_error_flag(fe),
    .rx_valid(rx_valid), .busy(busy));
  arx_tx_model tx (.clk_sys(clk_sys), .line(pin));

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // capture every finished frame
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) got_q.push_back({fe, rx_data});
  end

  function automatic logic [9:0] exp_data(input logic [9:0] v, input int n);
    return v & ((10'h001 << n) - 10'h001);
  endfunction : exp_data

  task automatic check(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (e !== g) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // wait bounded for one frame, compare error flag and data
  task automatic expect_frame(input logic [9:0] v, input int n, input logic stp);
    for (int w = 0; w < 400 && got_q.size() == 0; w++) @(negedge clk_sys);
    if (got_q.size() == 0) check("frame count", 11'h001, 11'h000);
    else check("frame", {~stp, exp_data(v, n)}, got_q.pop_front());
  endtask : expect_frame

  task automatic end_of_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end

  initial begin
    seed = 77164;
    n_fail = 0;
    n_tests = 0;
    en = 1'b0;
    ds = 1'b0;
    fb = 4'h8;
    div = 12'h001;
    resetn = 1'b0;
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    check("reset outputs", 11'h000, {fe, rx_data});
    en = 1'b1;
    repeat (4) @(negedge clk_sys);
    // random frames, both speeds, rate jitter at normal speed only
    for (int k = 0; k < 30; k++) begin
      ds = 1'($random(seed));
      nb = (k < 6) ? 5 + k : 5 + int'($unsigned($random(seed)) % 6);
      d = 10'($random(seed));
      bc = ds ? 16 : 31 + int'($unsigned($random(seed)) % 3);
      fb = 4'(nb);
      tx.send(d, nb, 1'b1, bc, bc);
      expect_frame(d, nb, 1'b1);
    end
    // zero stop bit in both modes
    for (int m = 0; m < 2; m++) begin
      ds = 1'(m);
      fb = 4'h8;
      d = 10'($random(seed));
      tx.send(d, 8, 1'b0, m ? 16 : 32, m ? 16 : 32);
      tx.hold(1'b1, 40);
      expect_frame(d, 8, 1'b0);
    end
    // short low pulse is rejected, then a good frame follows
    for (int m = 0; m < 2; m++) begin
      ds = 1'(m);
      tx.hold(1'b0, 8);
      tx.hold(1'b1, 40);
      check("noise busy frames", 11'h000, {busy, 10'(got_q.size())});
      d = 10'($random(seed));
      tx.send(d, 8, 1'b1, m ? 16 : 32, m ? 16 : 32);
      expect_frame(d, 8, 1'b1);
    end
    // next start right after the stop votes
    ds = 1'b0;
    d = 10'($random(seed));
    d2 = 10'($random(seed));
    tx.send(d, 8, 1'b1, 32, 24);
    tx.send(d2, 8, 1'b1, 32, 32);
    expect_frame(d, 8, 1'b1);
    expect_frame(d2, 8, 1'b1);
    fork
      tx.send(10'h0a5, 8, 1'b1, 32, 32);
      begin
        repeat (100) @(negedge clk_sys);
        check("busy in frame", 11'h001, {10'h000, busy});
        en = 1'b0;
        @(negedge clk_sys);
        check("busy after off", 11'h000, {10'h000, busy});
      end
    join
    en = 1'b1;
    repeat (40) @(negedge clk_sys);
    check("dropped frames", 11'h000, 11'(got_q.size()));
    end_of_test();
  end
endmodule : arx_rx_recovery_tb

// File: tb/arx_tx_model.sv
`timescale 1ns/1ps
// remote sender, lsb first, line idle high
module arx_tx_model (
  // clock
  input wire logic clk_sys,
  // serial line
  output logic line
);
  initial line = 1'b1;
  // hold a level for n clocks
  task automatic hold(input logic v, input int n);
    line = v;
    repeat (n) @(negedge clk_sys);
  endtask : hold
  // start and data bit length bc, stop bit length sc, set by caller
  task automatic send(input logic [9:0] d, input int nb, input logic stp,
                      input int bc, input int sc);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++) hold(d[i], bc);
    hold(stp, sc);
    line = 1'b1;
  endtask : send
endmodule : arx_tx_model
